// file: logic/rtcf_flags_ctrl.sv
`timescale 1ns/1ps
`include "rtcf_defs.svh"

// Summary of operation
// - Oscillator stopped flag set if the oscillator is enabled but idle for the first 5ms after power-up
// - Oscillator stopped flag clears only by host
// - Update hold freezes readable clock registers
// - Writes other than hold and snap bits only accepted while hold set
// - Clearing hold loads changed time into counters
// - Update hold bit is zero after power-up
module rtcf_flags_ctrl #(
  parameter int OSC_WAIT_CYC = `RTCF_OSC_WAIT_CYC,
  parameter int OSC_PER_SEC  = `RTCF_OSC_PER_SEC
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // Asynchronous memory bus pins
  input  wire logic          ce_n,
  input  wire logic          oe_n,
  input  wire logic          we_n,
  input  wire logic [16:0]   addr,
  input  wire logic [7:0]    dq_i,
  output      logic [7:0]    dq_o,
  output      logic          dq_oe,
  // Oscillator pins
  input  wire logic          osc_clk,
  input  wire logic          osc_enable,
  // Event strobes from on-chip logic
  input  wire logic          wdog_expire,
  input  wire logic          alarm_match,
  input  wire logic          power_fail,
  // Status
  output      logic          oscillator_stopped_flag
);
  import rtcf_pkg::*;

  if (OSC_WAIT_CYC < 2 || OSC_WAIT_CYC > 262143) begin : g_bad_wait
    $error("OSC_WAIT_CYC out of range");
  end
  if (OSC_PER_SEC < 1 || OSC_PER_SEC > 65536) begin : g_bad_per
    $error("OSC_PER_SEC out of range");
  end

  localparam logic [17:0] WAIT_LAST = 18'(OSC_WAIT_CYC - 1);
  localparam logic [15:0] PER_LAST  = 16'(OSC_PER_SEC - 1);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0]    rst_sync_ff;
  logic          rst_n;
  rtcf_pins_type pins_raw;
  rtcf_pins_type p;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  assign pins_raw = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, osc_clk: osc_clk,
                      osc_enable: osc_enable, addr: addr, dq: dq_i};

  // Strobes idle high so reset release does not look like a write
  rtcf_sync #(
    .W       ($bits(rtcf_pins_type)),
    .RST_VAL ({3'h7, {($bits(rtcf_pins_type) - 3){1'b0}}})
  ) i_rtcf_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (pins_raw),
    .q       (p)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rtcf_regs_type s_ff;
  rtcf_regs_type nxt_s;
  logic          wr_edge;
  logic          rd_act;
  logic          flags_hit;
  logic          sec_hit;
  logic          osc_edge;
  logic          base_load;

  function automatic logic [7:0] flags_byte(input rtcf_regs_type r);
    logic [7:0] b;
    b = `RTCF_FLAGS_RST;
    b[`RTCF_BIT_WDOG]    = r.wdog;
    b[`RTCF_BIT_ALARM]   = r.alarm;
    b[`RTCF_BIT_PFAIL]   = r.pfail;
    b[`RTCF_BIT_OSCSTOP] = r.oscstop;
    b[`RTCF_BIT_CAL]     = r.cal;
    b[`RTCF_BIT_HOLD]    = r.hold;
    b[`RTCF_BIT_SNAP]    = r.snap;
    return b;
  endfunction

  assign wr_edge   = !s_ff.we_prev && p.we_n && !p.ce_n;
  assign rd_act    = !p.ce_n && !p.oe_n && p.we_n;
  assign flags_hit = (p.addr == `RTCF_FLAGS_ADDR);
  assign sec_hit   = (p.addr == `RTCF_SEC_ADDR);
  assign osc_edge  = p.osc_clk && !s_ff.osc_prev;
  assign base_load = wr_edge && flags_hit && s_ff.hold && !p.dq[`RTCF_BIT_HOLD]
                     && s_ff.changed;

  always_comb begin
    nxt_s          = s_ff;
    nxt_s.we_prev  = p.we_n;
    nxt_s.osc_prev = p.osc_clk;
    nxt_s.rd_prev  = rd_act && flags_hit;

    // Event flags clear when a flags read ends
    if (s_ff.rd_prev && !(rd_act && flags_hit)) begin
      nxt_s.wdog  = 1'b0;
      nxt_s.alarm = 1'b0;
      nxt_s.pfail = 1'b0;
    end

    // Timekeeping counters run from the oscillator
    if (osc_edge && p.osc_enable) begin
      if (s_ff.div_cnt == PER_LAST) begin
        nxt_s.div_cnt  = 16'h0000;
        nxt_s.time_cnt = (s_ff.time_cnt == `RTCF_SEC_MAX) ? 8'h00 : s_ff.time_cnt + 8'h01;
      end else begin
        nxt_s.div_cnt = s_ff.div_cnt + 16'h0001;
      end
    end

    // Host writes
    if (wr_edge && flags_hit) begin
      nxt_s.hold = p.dq[`RTCF_BIT_HOLD];
      nxt_s.snap = p.dq[`RTCF_BIT_SNAP];
      if (s_ff.hold) begin
        nxt_s.cal = p.dq[`RTCF_BIT_CAL];
        if (!p.dq[`RTCF_BIT_OSCSTOP]) begin
          nxt_s.oscstop = 1'b0;
        end
      end
      if (!p.dq[`RTCF_BIT_HOLD]) begin
        nxt_s.changed = 1'b0;
      end
    end else if (wr_edge && sec_hit && s_ff.hold) begin
      nxt_s.sec_reg = p.dq;
      nxt_s.changed = 1'b1;
    end

    // New base time wins over a tick in the same cycle
    if (base_load) begin
      nxt_s.time_cnt = s_ff.sec_reg;
      nxt_s.div_cnt  = 16'h0000;
    end

    // Readable copy frozen while held or snapshotted
    if (!s_ff.hold && !s_ff.snap && !base_load) begin
      nxt_s.sec_reg = nxt_s.time_cnt;
    end

    // Power-up oscillator check
    case (s_ff.st)
      rtcf_st_check: begin
        if (osc_edge) begin
          nxt_s.osc_seen = 1'b1;
        end
        if (s_ff.wait_cnt == WAIT_LAST) begin
          nxt_s.st = rtcf_st_run;
          if (p.osc_enable && !s_ff.osc_seen && !osc_edge) begin
            nxt_s.oscstop = 1'b1;
          end
        end else begin
          nxt_s.wait_cnt = s_ff.wait_cnt + 18'h00001;
        end
      end
      rtcf_st_run: begin
        nxt_s.wait_cnt = s_ff.wait_cnt;
      end
      default: begin
        nxt_s.st = rtcf_st_check;
      end
    endcase

    // Events set after clears so a coincident event is kept
    if (wdog_expire) begin
      nxt_s.wdog = 1'b1;
    end
    if (alarm_match) begin
      nxt_s.alarm = 1'b1;
    end
    if (power_fail) begin
      nxt_s.pfail = 1'b1;
    end

    if (flags_hit) begin
      nxt_s.dq_out = flags_byte(s_ff);
    end else if (sec_hit) begin
      nxt_s.dq_out = s_ff.sec_reg;
    end else begin
      nxt_s.dq_out = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff         <= '0;
      s_ff.st      <= rtcf_st_check;
      s_ff.we_prev <= 1'b1;
      s_ff.hold    <= 1'b0;
      s_ff.sec_reg <= `RTCF_SEC_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dq_o                    = s_ff.dq_out;
  assign dq_oe                   = rd_act && (flags_hit || sec_hit);
  assign oscillator_stopped_flag = s_ff.oscstop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_osc_stop_set: assert property (
    (s_ff.st == rtcf_st_check && s_ff.wait_cnt == WAIT_LAST && p.osc_enable
     && !s_ff.osc_seen && !osc_edge) |=> s_ff.oscstop && s_ff.st == rtcf_st_run)
    else $error("oscillator stopped flag not set after silent window");
  chk_osc_stop_sticky: assert property (
    s_ff.oscstop && !(wr_edge && flags_hit && s_ff.hold) |=> s_ff.oscstop)
    else $error("oscillator stopped flag cleared without host write");
  chk_clock_freeze: assert property (
    (s_ff.hold || s_ff.snap) && !wr_edge |=> $stable(s_ff.sec_reg))
    else $error("clock register changed while frozen");
  chk_write_gate: assert property (
    wr_edge && !s_ff.hold |=> s_ff.cal == $past(s_ff.cal) && !s_ff.changed)
    else $error("write accepted without update hold");
  chk_base_load: assert property (
    base_load |=> s_ff.time_cnt == $past(s_ff.sec_reg) && !s_ff.hold)
    else $error("new base time not loaded");
  chk_hold_reset: assert property (@(posedge ref_clk)
    $rose(rst_n) |-> !s_ff.hold ##1 !s_ff.hold)
    else $error("update hold not zero after reset");
  chk_flag_layout: assert property (
    flags_hit |=> s_ff.dq_out[7:4] == {$past(s_ff.wdog), $past(s_ff.alarm),
                  $past(s_ff.pfail), $past(s_ff.oscstop)}
                  && s_ff.dq_out[1:0] == {$past(s_ff.hold), $past(s_ff.snap)})
    else $error("flags byte layout wrong");

  cov_osc_stop: cover property (!s_ff.oscstop ##1 s_ff.oscstop);
  cov_base_load: cover property (base_load);
  cov_read_clear: cover property (s_ff.wdog ##1 !s_ff.wdog);

endmodule

// file: logic/rtcf_defs.svh
`ifndef RTCF_DEFS_SVH
`define RTCF_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RTCF_FLAGS_ADDR    17'h1fff0
`define RTCF_SEC_ADDR      17'h1fff9
`define RTCF_FLAGS_RST     8'h00
`define RTCF_SEC_RST       8'h00

// ----------------------------------------------------------------
// Status and control byte fields
// ----------------------------------------------------------------
`define RTCF_BIT_WDOG      7
`define RTCF_BIT_ALARM     6
`define RTCF_BIT_PFAIL     5
`define RTCF_BIT_OSCSTOP   4
`define RTCF_BIT_CAL       2
`define RTCF_BIT_HOLD      1
`define RTCF_BIT_SNAP      0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTCF_OSC_WAIT_US   5000
`define RTCF_CLK_MHZ       50
`define RTCF_OSC_WAIT_CYC  (`RTCF_OSC_WAIT_US * `RTCF_CLK_MHZ)
`define RTCF_OSC_PER_SEC   32768
`define RTCF_SEC_MAX       8'h3b

`endif

// file: logic/rtcf_pkg.sv
package rtcf_pkg;

  typedef enum logic [1:0] {
    rtcf_st_check = 2'b00,
    rtcf_st_run   = 2'b01
  } rtcf_state_type;

  // Host bus and oscillator pins after synchronisation
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        osc_clk;
    logic        osc_enable;
    logic [16:0] addr;
    logic [7:0]  dq;
  } rtcf_pins_type;

  typedef struct packed {
    rtcf_state_type st;
    logic [17:0]    wait_cnt;
    logic           osc_seen;
    logic           osc_prev;
    logic           we_prev;
    logic           rd_prev;
    logic           wdog;
    logic           alarm;
    logic           pfail;
    logic           oscstop;
    logic           cal;
    logic           hold;
    logic           snap;
    logic           changed;
    logic [7:0]     sec_reg;
    logic [7:0]     time_cnt;
    logic [15:0]    div_cnt;
    logic [7:0]     dq_out;
  } rtcf_regs_type;

endpackage

// file: logic/rtcf_sync.sv
`timescale 1ns/1ps
module rtcf_sync #(
  parameter int                 W       = 1,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

// file: bench/rtcf_host.sv
`timescale 1ns/1ps
module rtcf_host (
  // Clock
  input  wire logic        ref_clk,
  // Bus pins driven by the host
  output      logic        ce_n,
  output      logic        oe_n,
  output      logic        we_n,
  output      logic [16:0] addr,
  output      logic [7:0]  dq_i,
  // Device side of the data pins
  input  wire logic [7:0]  dq_o,
  input  wire logic        dq_oe,
  // Raised when the device never answers a read
  output      logic        hung
);
  logic       drv;
  logic [7:0] wdat;

  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 17'h00000;
    drv  = 1'b0;
    wdat = 8'h00;
    hung = 1'b0;
  end

  // Released pins show the inverse of the last byte, so stale data never passes
  assign dq_i = dq_oe ? dq_o : (drv ? wdat : ~wdat);

  // Write strobe low and high long enough for the pin synchronisers
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    ce_n <= 1'b0;
    addr <= a;
    wdat <= d;
    drv  <= 1'b1;
    we_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    we_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ce_n <= 1'b1;
    drv  <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask

  // Device outputs are looked at on the falling edge, where they have settled
  task automatic rd(input logic [16:0] a, output logic [7:0] d);
    int n;
    n = 0;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    @(negedge ref_clk);
    while (dq_oe !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20)
      hung <= 1'b1;
    // Read data stands one cycle after the drive enable
    @(negedge ref_clk);
    d = dq_o;
    @(posedge ref_clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
endmodule

// file: bench/rtcf_flags_ctrl_tb.sv
`timescale 1ns/1ps
`include "rtcf_defs.svh"
module rtcf_flags_ctrl_tb;
  localparam logic [16:0] FADDR = `RTCF_FLAGS_ADDR;
  localparam logic [16:0] SADDR = `RTCF_SEC_ADDR;
  logic        ref_clk, nrst, ce_n, oe_n, we_n, dq_oe, hung;
  logic [16:0] addr;
  logic [7:0]  dq_i, dq_o, rv;
  logic        osc_clk, osc_enable, wdog_expire, alarm_match, power_fail, osf;
  int          bad_count, checks;

  rtcf_flags_ctrl #(.OSC_WAIT_CYC(20), .OSC_PER_SEC(4)) i_rtcf_flags_ctrl (
    .ref_clk(ref_clk), .nrst(nrst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .osc_clk(osc_clk),
    .osc_enable(osc_enable), .wdog_expire(wdog_expire), .alarm_match(alarm_match),
    .power_fail(power_fail), .oscillator_stopped_flag(osf));
  rtcf_host i_rtcf_host (.ref_clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .hung(hung));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Oscillator ticks; the pin stands low between bursts
  task automatic tick(input int n);
    repeat (n) begin
      osc_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      osc_clk <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  task automatic t_power_up();
    repeat (40) @(posedge ref_clk);
    check({7'h00, osf}, 8'h01);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h10);
  endtask

  task automatic t_osc_ack();
    i_rtcf_host.wr(FADDR, 8'h00);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h10);
    i_rtcf_host.wr(FADDR, 8'h02);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h12);
    i_rtcf_host.wr(FADDR, 8'h02);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h02);
    check({7'h00, osf}, 8'h00);
  endtask

  task automatic t_base_time();
    i_rtcf_host.wr(SADDR, 8'h05);
    i_rtcf_host.wr(FADDR, 8'h00);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h05);
    i_rtcf_host.wr(SADDR, 8'h20);
    i_rtcf_host.wr(FADDR, 8'h04);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h05);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h00);
  endtask

  task automatic t_freeze();
    i_rtcf_host.wr(FADDR, 8'h02);
    tick(8);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h05);
    i_rtcf_host.wr(FADDR, 8'h00);
    tick(4);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h08);
  endtask

  // Calibration and snapshot bits in place; snapshot freezes the seconds copy
  task automatic t_snap();
    i_rtcf_host.wr(FADDR, 8'h02);
    i_rtcf_host.wr(FADDR, 8'h06);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h06);
    i_rtcf_host.wr(FADDR, 8'h01);
    i_rtcf_host.rd(FADDR, rv);
    check(rv, 8'h01);
    tick(4);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h08);
    i_rtcf_host.wr(FADDR, 8'h00);
    i_rtcf_host.rd(SADDR, rv);
    check(rv, 8'h09);
  endtask

  // Each event lands in its own bit and is gone after one read
  task automatic t_events();
    for (int i = 0; i < 3; i++) begin
      {wdog_expire, alarm_match, power_fail} <= 3'b100 >> i;
      @(posedge ref_clk);
      {wdog_expire, alarm_match, power_fail} <= 3'b000;
      repeat (3) @(posedge ref_clk);
      i_rtcf_host.rd(FADDR, rv);
      check(rv, {3'b100 >> i, 5'h00});
      i_rtcf_host.rd(FADDR, rv);
      check(rv, 8'h00);
    end
  endtask

  always @(posedge hung) begin
    bad_count++;
    print_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    nrst = 1'b0;
    osc_clk = 1'b0;
    osc_enable = 1'b1;
    wdog_expire = 1'b0;
    alarm_match = 1'b0;
    power_fail = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_power_up();
    t_osc_ack();
    t_base_time();
    t_freeze();
    t_snap();
    t_events();
    print_verdict();
  end
endmodule
